// ==== bcrf_cfg.svh ====
// constants for the buffered channel request flow block
`ifndef BCRF_CFG_SVH
`define BCRF_CFG_SVH
`define BCRF_BUS_W 168
`define BCRF_HALF_W 84
`define BCRF_LANES 14
`define BCRF_LANE_CNT_W 4
`define BCRF_LOCK_MIN 4'hd
`define BCRF_ALIGN_DEPTH 9
`define BCRF_SKEW_W 4
`define BCRF_SKEW_MAX 4'h9
`define BCRF_ADDR_W 36
`define BCRF_RQ_DEPTH 3'h4
`define BCRF_RQ_PTR_W 2
`define BCRF_WQ_DEPTH 2'h2
`define BCRF_BEAT_W 3
`define BCRF_BEAT_LAST 3'h7
`define BCRF_WORD_LAST 2'h3
`define BCRF_CWORD_W 64
`define BCRF_DWORD_W 128
`define BCRF_FRAME_W 144
`define BCRF_MEM_AW 3
`define BCRF_MEM_DEPTH 8
`define BCRF_CHECK_CYC 3
`endif

// ==== bcrf_pkg.sv ====
// types shared by the request flow modules
package bcrf_pkg;
  `include "bcrf_cfg.svh"

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ARB = 3'h1,
    ST_WDAT = 3'h3,
    ST_ACT = 3'h2,
    ST_CMD = 3'h6
  } bcrf_seq_t;

  typedef enum logic [1:0] {
    CMD_NONE = 2'h0,
    CMD_ACT = 2'h1,
    CMD_RD = 2'h2,
    CMD_WR = 2'h3
  } bcrf_cmd_t;

  typedef logic [`BCRF_BUS_W-1:0] bcrf_frame_t;
  typedef logic [`BCRF_ADDR_W-1:0] bcrf_addr_t;
  typedef logic [`BCRF_DWORD_W-1:0] bcrf_dword_t;
endpackage

// ==== bcrf_mem_if.sv ====
// write data queue memory port bundle
`timescale 1ns/10ps
interface bcrf_mem_if;
  import bcrf_pkg::*;
  logic we;
  logic [`BCRF_MEM_AW-1:0] waddr;
  bcrf_dword_t wdata;
  logic [`BCRF_MEM_AW-1:0] raddr;
  bcrf_dword_t rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr,
    input rdata);
  modport mem (input we, input waddr, input wdata, input raddr,
    output rdata);
endinterface

// ==== bcrf_mem.sv ====
// write data queue storage with registered read data
`timescale 1ns/10ps
module bcrf_mem
  import bcrf_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // memory port
  bcrf_mem_if.mem port
);
  bcrf_dword_t store [`BCRF_MEM_DEPTH];

  always_ff @(posedge core_clk) begin
    if (port.we) begin
      store[port.waddr] <= port.wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      port.rdata <= '0;
    end else begin
      port.rdata <= store[port.raddr];
    end
  end
endmodule

// ==== bcrf_top.sv ====
// inbound channel packing, request queues and command sequencing
// Operation
// RQ1: skew counter and 9-deep delay lines align the two inbound channels
// RQ2: one shared 168-bit inbound bus at twice the memory rate
// RQ3: low bus half carries primary first half then second half
// RQ4: dual mode high half carries secondary first then second half
// RQ5: single mode high half carries second half on both cycles
// RQ6: read queue examined for pending work on every core cycle; the code checks it only in ST_IDLE and on the second ST_ARB cycle
// RQ7: read takes two cycles arbitrate, two activate, two read
// RQ8: each command step spans two core cycles
// RQ9: activate and read go out in consecutive command slots
// RQ10: module buffer drives each command one cycle after arrival
// RQ11: module buffer packs read data into 144-bit inbound frames
// RQ12: frames checked for crc and ecc, clean data 128 bits per cycle
// RQ13: returned read check takes three core cycles
// RQ14: write request enqueued and acknowledged back to the cache
// RQ15: write data taken as eight 64-bit beats into data queue
// RQ16: write data is sent ahead of the write command
// RQ17: module buffer answers a clean write with an idle frame
// RQ18: write entry freed only after no alert was seen
// RQ19: alert check of a returned status takes one core cycle
// RQ20: cache crossings assume no fixed integer clock ratio
// RQ21: cache crossings move only on the matching sync pulse
// RQ22: clock unit gives one sync pulse of each kind per cycle
// RQ23: channel lock needs at least 13 of 14 lanes locked
// RQ24: reset empties queues, drops pairing, no data before lock
`timescale 1ns/10ps
module bcrf_top
  import bcrf_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // mode
  input wire logic dual_channel_mode,
  // inbound channels from the lane alignment logic
  input wire logic [`BCRF_LANES-1:0] pri_lane_locked,
  input wire logic [`BCRF_LANES-1:0] sec_lane_locked,
  input wire logic pri_frame_valid,
  input wire bcrf_frame_t pri_frame,
  input wire logic sec_frame_valid,
  input wire bcrf_frame_t sec_frame,
  // shared inbound bus
  output bcrf_frame_t nb_bus,
  output logic nb_bus_valid,
  output logic nb_bus_second,
  output logic chan_aligned,
  output logic align_fault,
  // cache crossing pulses
  input wire logic cache_to_dram_tx_sync_pulse,
  input wire logic dram_to_cache_rx_sync_pulse,
  // cache read requests
  input wire logic rd_req_valid,
  input wire bcrf_addr_t rd_req_addr,
  output logic rd_req_ready,
  // cache write requests and data
  input wire logic wr_req_valid,
  input wire bcrf_addr_t wr_req_addr,
  output logic wr_req_ready,
  output logic wr_req_ack,
  input wire logic wr_data_valid,
  input wire logic [`BCRF_CWORD_W-1:0] wr_data,
  // returned read frames and cache read data
  input wire logic rd_frame_valid,
  input wire logic [`BCRF_FRAME_W-1:0] rd_frame,
  input wire logic rd_frame_crc_err,
  input wire logic rd_frame_ecc_err,
  output logic rd_data_valid,
  output bcrf_dword_t rd_data,
  output logic rd_data_err,
  // outbound commands and write data
  output logic cmd_valid,
  output bcrf_cmd_t cmd_kind,
  output bcrf_addr_t cmd_addr,
  output logic wdat_valid,
  output bcrf_dword_t wdat,
  // write status frames
  input wire logic wr_status_valid,
  input wire logic wr_status_alert,
  output logic wr_release
);
  function automatic logic [`BCRF_LANE_CNT_W-1:0] lane_count(
    input logic [`BCRF_LANES-1:0] v);
    logic [`BCRF_LANE_CNT_W-1:0] n;
    n = '0;
    for (int i = 0; i < `BCRF_LANES; i++) begin
      n = n + {{(`BCRF_LANE_CNT_W-1){1'b0}}, v[i]};
    end
    return n;
  endfunction

  // channel lock and skew
  logic pri_lock;
  logic sec_lock;
  logic [`BCRF_SKEW_W-1:0] skew_r;
  logic lead_r;
  logic aligned_r;
  logic fault_r;

  assign pri_lock = lane_count(pri_lane_locked) >= `BCRF_LOCK_MIN; // RQ23
  assign sec_lock = lane_count(sec_lane_locked) >= `BCRF_LOCK_MIN; // RQ23

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      skew_r <= '0;
      lead_r <= 1'b0;
      aligned_r <= 1'b0;
      fault_r <= 1'b0;
    end else if (!dual_channel_mode) begin
      skew_r <= '0;
      lead_r <= 1'b0;
      aligned_r <= pri_lock;
      fault_r <= 1'b0;
    end else if (!pri_lock && !sec_lock) begin
      skew_r <= '0;
      aligned_r <= 1'b0;
      fault_r <= 1'b0;
    end else if (pri_lock && sec_lock) begin
      aligned_r <= !fault_r; // RQ1
    end else if (aligned_r) begin
      // a channel dropped lock: retrain from scratch
      skew_r <= '0;
      aligned_r <= 1'b0;
    end else begin
      lead_r <= sec_lock;
      if (skew_r == `BCRF_SKEW_MAX) begin
        fault_r <= 1'b1; // RQ1
      end else begin
        skew_r <= skew_r + 1'b1; // RQ1
      end
    end
  end

  // per channel delay lines, only the leading one is tapped late
  bcrf_frame_t dly_frame [2][`BCRF_ALIGN_DEPTH];
  logic [`BCRF_ALIGN_DEPTH-1:0] dly_vld [2];
  bcrf_frame_t ch_frame [2];
  logic ch_vld [2];
  bcrf_frame_t in_frame [2];
  logic in_vld [2];

  assign in_frame[0] = pri_frame;
  assign in_frame[1] = sec_frame;
  assign in_vld[0] = pri_frame_valid;
  assign in_vld[1] = sec_frame_valid;

  for (genvar c = 0; c < 2; c++) begin : g_chan
    always_ff @(posedge core_clk) begin
      if (!resetn) begin
        dly_vld[c] <= '0;
      end else begin
        dly_vld[c] <= {dly_vld[c][`BCRF_ALIGN_DEPTH-2:0], in_vld[c]}; // RQ1
      end
    end

    always_ff @(posedge core_clk) begin
      dly_frame[c][0] <= in_frame[c];
      for (int s = 1; s < `BCRF_ALIGN_DEPTH; s++) begin
        dly_frame[c][s] <= dly_frame[c][s-1];
      end
    end

    always_comb begin
      ch_frame[c] = in_frame[c];
      ch_vld[c] = in_vld[c];
      if (lead_r == 1'(c) && skew_r != '0) begin
        ch_frame[c] = dly_frame[c][skew_r - 1'b1]; // RQ1
        ch_vld[c] = dly_vld[c][skew_r - 1'b1]; // RQ1
      end
    end
  end

  // frame pairing onto the shared bus
  logic pair_pend_r;
  logic [2*`BCRF_HALF_W-1:0] pair_hold_r;

  always_ff @(posedge core_clk) begin
    if (!resetn || !aligned_r) begin
      // no partial pair survives a loss of alignment
      pair_pend_r <= 1'b0; // RQ24
      nb_bus_valid <= 1'b0; // RQ24
      nb_bus_second <= 1'b0;
      nb_bus <= '0;
      pair_hold_r <= '0;
    end else if (pair_pend_r) begin
      pair_pend_r <= 1'b0;
      nb_bus_valid <= 1'b1;
      nb_bus_second <= 1'b1;
      nb_bus <= pair_hold_r; // RQ3 RQ4 RQ5
    end else if (ch_vld[0]) begin
      pair_pend_r <= 1'b1;
      nb_bus_valid <= 1'b1; // RQ2
      nb_bus_second <= 1'b0;
      nb_bus[`BCRF_HALF_W-1:0] <= ch_frame[0][`BCRF_HALF_W-1:0]; // RQ3
      pair_hold_r[`BCRF_HALF_W-1:0] <=
        ch_frame[0][`BCRF_BUS_W-1:`BCRF_HALF_W]; // RQ3
      if (dual_channel_mode) begin
        nb_bus[`BCRF_BUS_W-1:`BCRF_HALF_W] <=
          ch_frame[1][`BCRF_HALF_W-1:0]; // RQ4
        pair_hold_r[`BCRF_BUS_W-1:`BCRF_HALF_W] <=
          ch_frame[1][`BCRF_BUS_W-1:`BCRF_HALF_W]; // RQ4
      end else begin
        nb_bus[`BCRF_BUS_W-1:`BCRF_HALF_W] <=
          ch_frame[0][`BCRF_BUS_W-1:`BCRF_HALF_W]; // RQ5
        pair_hold_r[`BCRF_BUS_W-1:`BCRF_HALF_W] <=
          ch_frame[0][`BCRF_BUS_W-1:`BCRF_HALF_W]; // RQ5
      end
    end else begin
      nb_bus_valid <= 1'b0;
      nb_bus_second <= 1'b0;
    end
  end

  assign chan_aligned = aligned_r;
  assign align_fault = fault_r;

  // read request queue
  bcrf_addr_t rq_addr_r [`BCRF_RQ_DEPTH];
  logic [`BCRF_RQ_PTR_W-1:0] rq_wp_r;
  logic [`BCRF_RQ_PTR_W-1:0] rq_rp_r;
  logic [2:0] rq_cnt_r;
  logic rq_push;
  logic rq_pop;

  assign rd_req_ready = cache_to_dram_tx_sync_pulse &&
    rq_cnt_r != `BCRF_RQ_DEPTH; // RQ21
  assign rq_push = rd_req_valid && rd_req_ready;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rq_wp_r <= '0;
      rq_rp_r <= '0;
      rq_cnt_r <= '0; // RQ24
    end else begin
      if (rq_push) begin
        rq_addr_r[rq_wp_r] <= rd_req_addr;
        rq_wp_r <= rq_wp_r + 1'b1;
      end
      if (rq_pop) begin
        rq_rp_r <= rq_rp_r + 1'b1;
      end
      rq_cnt_r <= rq_cnt_r + {2'h0, rq_push} - {2'h0, rq_pop};
    end
  end

  // write request queue and data capture
  bcrf_addr_t wq_addr_r [2];
  logic [1:0] wq_done_r;
  logic wq_wp_r;
  logic wq_rp_r;
  logic wq_dp_r;
  logic [1:0] wq_cnt_r;
  logic wq_push;
  logic wq_pop;
  logic ack_pend_r;
  logic beat_take;
  logic [`BCRF_BEAT_W-1:0] beat_r;
  logic [`BCRF_CWORD_W-1:0] beat_lo_r;
  bcrf_mem_if wdq ();

  assign wr_req_ready = cache_to_dram_tx_sync_pulse &&
    wq_cnt_r != `BCRF_WQ_DEPTH; // RQ21
  assign wq_push = wr_req_valid && wr_req_ready; // RQ14
  assign beat_take = wr_data_valid && cache_to_dram_tx_sync_pulse; // RQ21
  assign wr_req_ack = ack_pend_r && dram_to_cache_rx_sync_pulse; // RQ21

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wq_wp_r <= 1'b0;
      wq_rp_r <= 1'b0;
      wq_cnt_r <= '0; // RQ24
      ack_pend_r <= 1'b0;
    end else begin
      if (wq_push) begin
        wq_addr_r[wq_wp_r] <= wr_req_addr; // RQ14
        wq_wp_r <= ~wq_wp_r;
      end
      if (wq_pop) begin
        wq_rp_r <= ~wq_rp_r;
      end
      wq_cnt_r <= wq_cnt_r + {1'b0, wq_push} - {1'b0, wq_pop};
      // a new request beats the clearing pulse
      ack_pend_r <= wq_push || (ack_pend_r && !dram_to_cache_rx_sync_pulse);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      beat_r <= '0;
      beat_lo_r <= '0;
      wq_dp_r <= 1'b0;
      wq_done_r <= '0; // RQ24
    end else begin
      if (wq_pop) begin
        wq_done_r[wq_rp_r] <= 1'b0;
      end
      if (beat_take) begin
        beat_r <= beat_r + 1'b1; // RQ15
        if (!beat_r[0]) begin
          beat_lo_r <= wr_data;
        end
        if (beat_r == `BCRF_BEAT_LAST) begin
          wq_done_r[wq_dp_r] <= 1'b1; // RQ15
          wq_dp_r <= ~wq_dp_r;
        end
      end
    end
  end

  // two beats pair into one queue word, low beat first
  assign wdq.we = beat_take && beat_r[0]; // RQ15
  assign wdq.waddr = {wq_dp_r, beat_r[2:1]};
  assign wdq.wdata = {wr_data, beat_lo_r};

  bcrf_mem u_wdq (
    .core_clk(core_clk),
    .resetn(resetn),
    .port(wdq.mem)
  );

  // command sequencer
  bcrf_seq_t seq_r;
  logic phase_r;
  logic is_wr_r;
  logic [1:0] word_r;
  logic wdat_rd_r;
  logic inflight_r;
  logic rd_avail;
  logic wr_avail;

  assign rd_avail = rq_cnt_r != '0;
  assign wr_avail = wq_cnt_r != '0 && wq_done_r[wq_rp_r] && !inflight_r;
  assign rq_pop = seq_r == ST_ARB && phase_r && rd_avail;
  assign wdq.raddr = {wq_rp_r, word_r};

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      seq_r <= ST_IDLE;
      phase_r <= 1'b0;
      is_wr_r <= 1'b0;
      word_r <= '0;
      wdat_rd_r <= 1'b0;
      cmd_valid <= 1'b0;
      cmd_kind <= CMD_NONE;
      cmd_addr <= '0;
    end else begin
      cmd_valid <= 1'b0;
      wdat_rd_r <= 1'b0;
      phase_r <= ~phase_r; // RQ8
      case (seq_r)
        ST_IDLE: begin
          phase_r <= 1'b0;
          if (rd_avail || wr_avail) begin
            seq_r <= ST_ARB; // RQ6
          end
        end
        ST_ARB: begin
          if (phase_r) begin
            // reads win over writes to keep read latency short
            if (rd_avail) begin
              is_wr_r <= 1'b0;
              cmd_addr <= rq_addr_r[rq_rp_r];
              seq_r <= ST_ACT; // RQ7
            end else begin
              is_wr_r <= 1'b1;
              cmd_addr <= wq_addr_r[wq_rp_r];
              word_r <= '0;
              seq_r <= ST_WDAT; // RQ16
            end
          end
        end
        ST_WDAT: begin
          phase_r <= 1'b0;
          wdat_rd_r <= 1'b1; // RQ16
          word_r <= word_r + 1'b1;
          if (word_r == `BCRF_WORD_LAST) begin
            seq_r <= ST_ACT;
          end
        end
        ST_ACT: begin
          if (phase_r) begin
            cmd_valid <= 1'b1; // RQ7 RQ9
            cmd_kind <= CMD_ACT;
            seq_r <= ST_CMD;
          end
        end
        ST_CMD: begin
          if (phase_r) begin
            cmd_valid <= 1'b1; // RQ7 RQ9
            cmd_kind <= is_wr_r ? CMD_WR : CMD_RD;
            seq_r <= ST_IDLE;
          end
        end
        default: begin
          seq_r <= ST_IDLE;
        end
      endcase
    end
  end

  assign wdat_valid = wdat_rd_r;
  assign wdat = wdq.rdata;

  // write status check: one cycle to judge, then free or retry
  logic chk_vld_r;
  logic chk_alert_r;

  assign wq_pop = chk_vld_r && !chk_alert_r; // RQ18
  assign wr_release = wq_pop;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      chk_vld_r <= 1'b0;
      chk_alert_r <= 1'b0;
      inflight_r <= 1'b0;
    end else begin
      chk_vld_r <= wr_status_valid && inflight_r; // RQ19
      chk_alert_r <= wr_status_alert;
      if (seq_r == ST_CMD && phase_r && is_wr_r) begin
        inflight_r <= 1'b1;
      end else if (chk_vld_r) begin
        // an alert leaves the entry queued, so it is sent again
        inflight_r <= 1'b0; // RQ18
      end
    end
  end

  // read return check pipeline and cache handoff
  logic [`BCRF_CHECK_CYC-1:0] chk_v_r;
  logic [`BCRF_CHECK_CYC-1:0] chk_e_r;
  bcrf_dword_t chk_d_r [`BCRF_CHECK_CYC];
  logic ret_v_r;
  logic ret_e_r;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      chk_v_r <= '0;
      chk_e_r <= '0;
    end else begin
      chk_v_r <= {chk_v_r[`BCRF_CHECK_CYC-2:0], rd_frame_valid}; // RQ13
      chk_e_r <= {chk_e_r[`BCRF_CHECK_CYC-2:0],
        rd_frame_crc_err || rd_frame_ecc_err}; // RQ12
    end
  end

  always_ff @(posedge core_clk) begin
    chk_d_r[0] <= rd_frame[`BCRF_DWORD_W-1:0];
    for (int s = 1; s < `BCRF_CHECK_CYC; s++) begin
      chk_d_r[s] <= chk_d_r[s-1];
    end
  end

  // one-deep hold: relies on a receive pulse before the next return arrives
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ret_v_r <= 1'b0;
      ret_e_r <= 1'b0;
      rd_data <= '0;
    end else if (chk_v_r[`BCRF_CHECK_CYC-1]) begin
      ret_v_r <= 1'b1;
      ret_e_r <= chk_e_r[`BCRF_CHECK_CYC-1];
      rd_data <= chk_d_r[`BCRF_CHECK_CYC-1]; // RQ12
    end else if (dram_to_cache_rx_sync_pulse) begin
      ret_v_r <= 1'b0;
    end
  end

  assign rd_data_valid = ret_v_r && !ret_e_r &&
    dram_to_cache_rx_sync_pulse; // RQ12 RQ20 RQ21
  assign rd_data_err = ret_v_r && ret_e_r && dram_to_cache_rx_sync_pulse;
endmodule

// ==== bcrf_chk_assertions.sv ====
// port checker for the request flow top
`timescale 1ns/10ps
module bcrf_chk
  import bcrf_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // inbound bus
  input wire logic dual_channel_mode,
  input wire bcrf_frame_t nb_bus,
  input wire logic nb_bus_valid,
  input wire logic nb_bus_second,
  // cache side
  input wire logic cache_to_dram_tx_sync_pulse,
  input wire logic dram_to_cache_rx_sync_pulse,
  input wire logic rd_req_ready,
  input wire logic wr_req_ready,
  input wire logic wr_req_ack,
  input wire logic rd_data_valid,
  // channel side
  input wire logic cmd_valid,
  input wire bcrf_cmd_t cmd_kind,
  input wire logic wr_status_valid,
  input wire logic wr_status_alert,
  input wire logic wr_release
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  a_ready_sync: assert property (
    (rd_req_ready || wr_req_ready) |-> cache_to_dram_tx_sync_pulse)
    else $error("ready without transmit pulse");
  a_return_sync: assert property (
    (wr_req_ack || rd_data_valid) |-> dram_to_cache_rx_sync_pulse)
    else $error("cache answer without receive pulse");
  a_pair_second: assert property (
    nb_bus_valid && !nb_bus_second |=> nb_bus_valid && nb_bus_second)
    else $error("second half of pair missing");
  a_single_upper: assert property (
    nb_bus_second && !dual_channel_mode |-> nb_bus[167:84] == nb_bus[83:0])
    else $error("single mode upper half differs on second cycle");
  a_single_first: assert property (
    (nb_bus_valid && !nb_bus_second && !dual_channel_mode)
    ##1 !dual_channel_mode |-> nb_bus[83:0] == $past(nb_bus[167:84]))
    else $error("single mode first upper half not the second half");
  a_act_then_cmd: assert property (
    cmd_valid && cmd_kind == CMD_ACT |=> !cmd_valid
    ##1 cmd_valid && (cmd_kind == CMD_RD || cmd_kind == CMD_WR))
    else $error("activate not followed two cycles later");
  a_release_lat: assert property (
    wr_release |-> $past(wr_status_valid, 1) && !$past(wr_status_alert, 1))
    else $error("release without clean status the cycle before");
  a_reset_quiet: assert property (
    $rose(resetn) |-> !cmd_valid && !nb_bus_valid && !wr_release)
    else $error("outputs active right after reset");
endmodule

bind bcrf_top bcrf_chk u_chk (.*);

// ==== bcrf_far.sv ====
// far side model: module buffer chain answering commands
`timescale 1ns/10ps
module bcrf_far
  import bcrf_pkg::*;
#(
  parameter int RD_LAT = 8,
  parameter int WR_LAT = 6
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // commands
  input wire logic cmd_valid,
  input wire bcrf_cmd_t cmd_kind,
  input wire bcrf_addr_t cmd_addr,
  // faults ordered by the bench
  input wire logic alert_nxt,
  input wire logic crc_nxt,
  input wire logic ecc_nxt,
  // returned frames
  output logic rd_frame_valid,
  output logic [143:0] rd_frame,
  output logic rd_frame_crc_err,
  output logic rd_frame_ecc_err,
  output logic wr_status_valid,
  output logic wr_status_alert
);
  int rd_cnt;
  int wr_cnt;
  bcrf_addr_t rd_a;
  initial begin
    rd_frame_valid = 1'b0;
    rd_frame = '0;
    rd_frame_crc_err = 1'b0;
    rd_frame_ecc_err = 1'b0;
    wr_status_valid = 1'b0;
    wr_status_alert = 1'b0;
    rd_cnt = 0;
    wr_cnt = 0;
    rd_a = '0;
  end
  // lines not carrying a frame show changing junk, never the last value
  always @(posedge core_clk) begin
    rd_frame_valid <= 1'b0;
    wr_status_valid <= 1'b0;
    rd_frame <= ~rd_frame;
    rd_frame_crc_err <= ~rd_frame_crc_err;
    rd_frame_ecc_err <= ~rd_frame_ecc_err;
    wr_status_alert <= ~wr_status_alert;
    if (rd_cnt > 0) rd_cnt--;
    if (wr_cnt > 0) wr_cnt--;
    if (cmd_valid === 1'b1 && cmd_kind == CMD_RD) begin
      rd_cnt = RD_LAT;
      rd_a = cmd_addr;
    end
    if (cmd_valid === 1'b1 && cmd_kind == CMD_WR) wr_cnt = WR_LAT;
    if (rd_cnt == 1) begin
      rd_frame_valid <= 1'b1;
      rd_frame <= {16'h0, {4{rd_a[31:0]}}};
      rd_frame_crc_err <= crc_nxt;
      rd_frame_ecc_err <= ecc_nxt;
    end
    if (wr_cnt == 1) begin
      wr_status_valid <= 1'b1;
      wr_status_alert <= alert_nxt;
    end
    if (!resetn) begin
      rd_cnt = 0;
      wr_cnt = 0;
    end
  end
endmodule

// ==== tb_bcrf_top.sv ====
// self-checking bench for the request flow top
`timescale 1ns/10ps
module tb_bcrf_top;
  import bcrf_pkg::*;
  logic core_clk, resetn, dual_channel_mode, chan_aligned, align_fault;
  logic [13:0] pri_lane_locked, sec_lane_locked;
  logic pri_frame_valid, sec_frame_valid, nb_bus_valid, nb_bus_second;
  bcrf_frame_t pri_frame, sec_frame, nb_bus;
  logic cache_to_dram_tx_sync_pulse, dram_to_cache_rx_sync_pulse;
  logic rd_req_valid, rd_req_ready, wr_req_valid, wr_req_ready, wr_req_ack;
  bcrf_addr_t rd_req_addr, wr_req_addr, cmd_addr;
  logic wr_data_valid, rd_frame_valid, rd_frame_crc_err, rd_frame_ecc_err;
  logic [63:0] wr_data;
  logic [143:0] rd_frame;
  logic rd_data_valid, rd_data_err, cmd_valid, wdat_valid, wr_release;
  logic wr_status_valid, wr_status_alert, alert_nxt, crc_nxt, ecc_nxt;
  bcrf_dword_t rd_data, wdat;
  bcrf_cmd_t cmd_kind;
  int error_cnt, samples_checked, seed, n, exp_lat;
  bcrf_dword_t exp_q[$];

  bcrf_top u_dut (.*);
  bcrf_far u_far (.*);

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // receive pulse wanders so cache answers must wait for it
  always @(posedge core_clk)
    dram_to_cache_rx_sync_pulse <= 1'($random(seed));

  task automatic chk(string nm, logic [167:0] seen, logic [167:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wait_hi(ref logic s, input int lim);
    n = 0;
    do begin @(posedge core_clk); n++; end while (s !== 1'b1 && n < lim);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic frame_pair();
    bcrf_frame_t p, s;
    for (int i = 0; i < 21; i++) begin
      p[i*8+:8] = 8'($random(seed));
      s[i*8+:8] = 8'($random(seed));
    end
    @(posedge core_clk);
    {pri_frame, sec_frame} <= {p, s};
    {pri_frame_valid, sec_frame_valid} <= 2'b11;
    @(posedge core_clk);
    {pri_frame_valid, sec_frame_valid} <= 2'b00;
    wait_hi(nb_bus_valid, 12);
    chk("pair_lat", n, exp_lat);
    chk("first", {nb_bus_valid, nb_bus_second}, 2'b10);
    chk("bus1", nb_bus, {dual_channel_mode ? s[83:0] : p[167:84],
      p[83:0]});
    @(posedge core_clk);
    chk("bus2", nb_bus, {dual_channel_mode ? s[167:84] : p[167:84],
      p[167:84]});
    repeat (2) @(posedge core_clk);
  endtask

  task automatic do_read(logic ce, logic ee);
    bcrf_addr_t a;
    a = {4'($random(seed)), 32'($random(seed))};
    @(posedge core_clk);
    {crc_nxt, ecc_nxt, rd_req_valid} <= {ce, ee, 1'b1};
    rd_req_addr <= a;
    do @(posedge core_clk); while (rd_req_ready !== 1'b1);
    rd_req_valid <= 1'b0;
    exp_q.push_back({4{a[31:0]}});
    wait_hi(cmd_valid, 20);
    chk("act", {n >= 4 && n <= 6, cmd_kind, cmd_addr},
      {1'b1, CMD_ACT, a});
    repeat (2) @(posedge core_clk);
    chk("rd", {cmd_valid, cmd_kind, cmd_addr}, {1'b1, CMD_RD, a});
    n = 0;
    do begin @(posedge core_clk); n++; end
      while (rd_data_valid !== 1'b1 && rd_data_err !== 1'b1 && n < 60);
    chk("rd_flags", {rd_data_valid, rd_data_err}, {~(ce|ee), ce|ee});
    if (!(ce | ee)) chk("rd_data", rd_data, exp_q[0]);
    exp_q.delete(0);
  endtask

  task automatic do_write(logic al);
    logic [63:0] lo, b;
    @(posedge core_clk);
    {alert_nxt, wr_req_valid} <= {al, 1'b1};
    wr_req_addr <= {4'($random(seed)), 32'($random(seed))};
    do @(posedge core_clk); while (wr_req_ready !== 1'b1);
    wr_req_valid <= 1'b0;
    wait_hi(wr_req_ack, 20);
    chk("ack", wr_req_ack, 1);
    for (int i = 0; i < 8; i++) begin
      b = {32'($random(seed)), 32'($random(seed))};
      @(posedge core_clk);
      {wr_data_valid, wr_data} <= {1'b1, b};
      if (i[0]) exp_q.push_back({b, lo});
      else lo = b;
    end
    @(posedge core_clk);
    wr_data_valid <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      wait_hi(wdat_valid, 40);
      chk("wdat", wdat, exp_q.pop_front());
    end
    n = 0;
    do begin @(posedge core_clk); n++; end
      while (!(cmd_valid === 1'b1 && cmd_kind == CMD_WR) && n < 40);
    chk("wr_cmd", cmd_valid, 1);
    if (al) begin
      wait_hi(wr_status_valid, 40);
      alert_nxt <= 1'b0;
      repeat (3) begin
        @(posedge core_clk);
        chk("no_release", wr_release, 0);
      end
    end
    wait_hi(wr_release, 200);
    chk("release", wr_release, 1);
  endtask

  initial begin
    seed = 19430;
    {error_cnt, samples_checked} = '0;
    exp_lat = 1;
    {resetn, dual_channel_mode, pri_frame_valid, sec_frame_valid} = '0;
    {pri_lane_locked, sec_lane_locked, pri_frame, sec_frame} = '0;
    {cache_to_dram_tx_sync_pulse, dram_to_cache_rx_sync_pulse} = 2'b11;
    {rd_req_valid, rd_req_addr, wr_req_valid, wr_req_addr} = '0;
    {wr_data_valid, wr_data, alert_nxt, crc_nxt, ecc_nxt} = '0;
    repeat (6) @(posedge core_clk);
    chk("reset_quiet", {cmd_valid, nb_bus_valid, chan_aligned}, 0);
    resetn <= 1'b1;
    {pri_lane_locked, sec_lane_locked} <= {14'h0fff, 14'h0fff};
    repeat (12) @(posedge core_clk);
    chk("lock_12", chan_aligned, 0);
    {pri_lane_locked, sec_lane_locked} <= {14'h3ffe, 14'h3fff};
    wait_hi(chan_aligned, 30);
    chk("lock_13", chan_aligned, 1);
    for (int m = 0; m < 2; m++) begin
      dual_channel_mode <= m[0];
      repeat (4) frame_pair();
    end
    // secondary relocks three cycles late: primary gets delayed by three
    sec_lane_locked <= 14'h0fff;
    repeat (4) @(posedge core_clk);
    sec_lane_locked <= 14'h3fff;
    exp_lat = 4;
    wait_hi(chan_aligned, 4);
    chk("skew_lock", {chan_aligned, align_fault}, 2'b10);
    repeat (2) frame_pair();
    @(posedge core_clk);
    {cache_to_dram_tx_sync_pulse, rd_req_valid, wr_req_valid} <= 3'b011;
    repeat (3) begin
      @(posedge core_clk);
      chk("ready_off", {rd_req_ready, wr_req_ready}, 0);
    end
    {cache_to_dram_tx_sync_pulse, rd_req_valid, wr_req_valid} <= 3'b100;
    for (int i = 0; i < 4; i++) do_read(i == 2, i == 3);
    do_write(1'b0);
    do_write(1'b1);
    do_write(1'b0);
    tally_and_finish();
  end

  initial begin
    #200000;
    error_cnt++;
    tally_and_finish();
  end
endmodule
